// ### include/swm_defines.svh
// Timing, command and check constants for the single-line bus master
`ifndef SWM_DEFINES_SVH
`define SWM_DEFINES_SVH
`define SWM_CLK_MHZ          200
`define SWM_RST_LOW_US       480
`define SWM_RST_HIGH_US      480
`define SWM_PRES_SMP_US      70
`define SWM_SLOT_US          70
`define SWM_W0_LOW_US        65
`define SWM_W1_LOW_US        6
`define SWM_RD_LOW_US        2
`define SWM_RD_SMP_US        12
`define SWM_REC_US           5
`define SWM_PROG_US          480
`define SWM_RST_LOW_CYC      (`SWM_RST_LOW_US * `SWM_CLK_MHZ)
`define SWM_RST_HIGH_CYC     (`SWM_RST_HIGH_US * `SWM_CLK_MHZ)
`define SWM_PRES_SMP_CYC     (`SWM_PRES_SMP_US * `SWM_CLK_MHZ)
`define SWM_SLOT_CYC         (`SWM_SLOT_US * `SWM_CLK_MHZ)
`define SWM_W0_LOW_CYC       (`SWM_W0_LOW_US * `SWM_CLK_MHZ)
`define SWM_W1_LOW_CYC       (`SWM_W1_LOW_US * `SWM_CLK_MHZ)
`define SWM_RD_LOW_CYC       (`SWM_RD_LOW_US * `SWM_CLK_MHZ)
`define SWM_RD_SMP_CYC       (`SWM_RD_SMP_US * `SWM_CLK_MHZ)
`define SWM_REC_CYC          (`SWM_REC_US * `SWM_CLK_MHZ)
`define SWM_PROG_CYC         (`SWM_PROG_US * `SWM_CLK_MHZ)
`define SWM_LINE_MAX_US      120
`define SWM_LINE_MAX_CYC     (`SWM_LINE_MAX_US * `SWM_CLK_MHZ)
`define SWM_BYTE_BITS        4'h8
`define SWM_TRIP_BITS        4'h3
`define SWM_CRC8_POLY        8'h8C
`define SWM_CRC16_POLY       16'hA001
`define SWM_CRC16_GOOD       16'hB001
`define SWM_CMD_READ_ID      8'h33
`define SWM_CMD_SELECT       8'h55
`define SWM_CMD_BYPASS       8'hCC
`define SWM_CMD_SEARCH       8'hF0
`endif

// ### include/swm_pkg.sv
// Types shared by the single-line bus master and its users
package swm_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b0_0001,
    ST_SLOT = 5'b0_0010,
    ST_REC  = 5'b0_0100,
    ST_PROG = 5'b0_1000,
    ST_SPR  = 5'b1_0000
  } swm_state_e;

  typedef enum logic [2:0] {
    OP_RESET = 3'h0,
    OP_WBYTE = 3'h1,
    OP_RBYTE = 3'h2,
    OP_TRIP  = 3'h3,
    OP_PROG  = 3'h4
  } swm_op_e;

  typedef struct packed {
    swm_op_e    op;
    logic [7:0] data;
    logic       dir;
  } swm_cmd_s;

  typedef struct packed {
    logic [7:0] data;
    logic       presence;
    logic       tripBit;
    logic       tripCmp;
    logic       error;
  } swm_rsp_s;
endpackage

// ### hw/swm_master.sv
// Single-line bus master: reset/presence, byte slots, search triplets, program pulse, check generators
`timescale 1ns/1ps
`include "swm_defines.svh"
module swm_master #(
  parameter int unsigned RST_LOW_CYC  = `SWM_RST_LOW_CYC,
  parameter int unsigned RST_HIGH_CYC = `SWM_RST_HIGH_CYC,
  parameter int unsigned PRES_SMP_CYC = `SWM_PRES_SMP_CYC,
  parameter int unsigned SLOT_CYC     = `SWM_SLOT_CYC,
  parameter int unsigned W0_LOW_CYC   = `SWM_W0_LOW_CYC,
  parameter int unsigned PROG_CYC     = `SWM_PROG_CYC
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             cmdValid,
  output logic                  cmdReady,
  input  wire swm_pkg::swm_cmd_s cmd,
  output logic                  rspValid,
  output swm_pkg::swm_rsp_s     rsp,
  input  wire logic             crcLoad,
  input  wire logic [15:0]      crcSeed,
  output logic [7:0]            crc8,
  output logic [15:0]           crc16,
  input  wire logic             lineIn,
  output logic                  lineOut,
  output logic                  lineOe,
  output logic                  progEnable
);
  import swm_pkg::*;

  localparam int CW = 18;
  localparam logic [CW-1:0] RstLow  = CW'(RST_LOW_CYC);
  localparam logic [CW-1:0] PresAt  = CW'(RST_LOW_CYC + PRES_SMP_CYC);
  localparam logic [CW-1:0] RstEnd  = CW'(RST_LOW_CYC + RST_HIGH_CYC);
  localparam logic [CW-1:0] SlotEnd = CW'(SLOT_CYC);
  localparam logic [CW-1:0] W0Low   = CW'(W0_LOW_CYC);
  localparam logic [CW-1:0] W1Low   = CW'(`SWM_W1_LOW_CYC);
  localparam logic [CW-1:0] RdLow   = CW'(`SWM_RD_LOW_CYC);
  localparam logic [CW-1:0] RdSmp   = CW'(`SWM_RD_SMP_CYC);
  localparam logic [CW-1:0] RecEnd  = CW'(`SWM_REC_CYC);
  localparam logic [CW-1:0] ProgEnd = CW'(PROG_CYC);
  localparam logic [CW-1:0] LineMax = CW'(`SWM_LINE_MAX_CYC);

  typedef struct packed {
    swm_state_e  st;
    swm_op_e     op;
    logic [CW-1:0] cnt;
    logic [CW-1:0] lowEnd;
    logic [CW-1:0] smpAt;
    logic [CW-1:0] slotEnd;
    logic [3:0]  bitIdx;
    logic [3:0]  nBits;
    logic [7:0]  shreg;
    logic        dir;
    logic        bitv;
    logic        drive;
    logic        prog;
    logic        rspValid;
    swm_rsp_s    rsp;
    logic [7:0]  crc8;
    logic [15:0] crc16;
    logic [CW-1:0] lowRun;
    logic [3:0]  slotCnt;
  } swm_regs_s;

  swm_regs_s s_q;
  swm_regs_s s_d;

  // Third bit of a triplet follows the only device answer, else the caller's choice
  function automatic logic sendBit(input swm_regs_s s);
    if (s.op == OP_TRIP)
      sendBit = (s.rsp.tripBit != s.rsp.tripCmp) ? s.rsp.tripBit : s.dir;
    else
      sendBit = s.shreg[0];
  endfunction

  function automatic logic isRead(input swm_regs_s s);
    isRead = (s.op == OP_RBYTE) || (s.op == OP_TRIP && s.bitIdx < 4'h2);
  endfunction

  // Every slot opens by driving the line low from count zero
  function automatic swm_regs_s startSlot(input swm_regs_s s);
    swm_regs_s r;
    r = s;
    r.st = ST_SLOT;
    r.cnt = '0;
    r.drive = 1'b1;
    r.slotCnt = s.slotCnt + 4'h1;
    if (s.op == OP_RESET)
    begin
      r.lowEnd = RstLow;
      r.smpAt = PresAt;
      r.slotEnd = RstEnd;
    end
    else if (isRead(s))
    begin
      r.lowEnd = RdLow;
      r.smpAt = RdSmp;
      r.slotEnd = SlotEnd;
    end
    else
    begin
      r.lowEnd = sendBit(s) ? W1Low : W0Low;
      r.smpAt = RdSmp;
      r.slotEnd = SlotEnd;
    end
    startSlot = r;
  endfunction

  always_comb
  begin
    s_d = s_q;
    if (ce)
    begin
      s_d.rspValid = 1'b0;
      s_d.lowRun = s_q.drive ? s_q.lowRun + CW'(1) : '0;
      case (s_q.st)
        ST_IDLE:
        begin
          s_d.drive = 1'b0;
          if (crcLoad)
          begin
            s_d.crc16 = crcSeed;
            s_d.crc8 = 8'h00;
          end
          if (cmdValid)
          begin
            s_d.op = cmd.op;
            s_d.shreg = cmd.data;
            s_d.dir = cmd.dir;
            s_d.bitIdx = 4'h0;
            s_d.slotCnt = 4'h0;
            s_d.rsp.error = 1'b0;
            s_d.nBits = (cmd.op == OP_TRIP) ? `SWM_TRIP_BITS :
                        (cmd.op == OP_RESET) ? 4'h1 :
                        (cmd.op == OP_PROG) ? 4'h0 : `SWM_BYTE_BITS;
            if (cmd.op == OP_PROG)
            begin
              // Programming a byte whose check has not come back clean would corrupt the part
              if (s_q.crc16 == `SWM_CRC16_GOOD)
              begin
                s_d.st = ST_PROG;
                s_d.cnt = '0;
                s_d.prog = 1'b1;
              end
              else
              begin
                s_d.rspValid = 1'b1;
                s_d.rsp.error = 1'b1;
              end
            end
            else
              s_d = startSlot(s_d);
          end
        end
        ST_SLOT:
        begin
          s_d.cnt = s_q.cnt + CW'(1);
          s_d.drive = s_d.cnt < s_q.lowEnd;
          if (s_q.cnt == s_q.smpAt)
          begin
            s_d.bitv = isRead(s_q) ? lineIn : sendBit(s_q);
            if (s_q.op == OP_RESET)
              s_d.rsp.presence = ~lineIn;
          end
          if (s_q.cnt == s_q.slotEnd)
          begin
            s_d.drive = 1'b0;
            s_d.cnt = '0;
            s_d.bitIdx = s_q.bitIdx + 4'h1;
            if (s_q.op == OP_RESET)
            begin
              s_d.st = ST_IDLE;
              s_d.rspValid = 1'b1;
              s_d.rsp.data = 8'h00;
            end
            else
            begin
              s_d.st = ST_REC;
              s_d.shreg = {s_q.bitv, s_q.shreg[7:1]};
              if (s_q.op == OP_TRIP && s_q.bitIdx == 4'h0)
                s_d.rsp.tripBit = s_q.bitv;
              if (s_q.op == OP_TRIP && s_q.bitIdx == 4'h1)
                s_d.rsp.tripCmp = s_q.bitv;
              if (s_q.op != OP_TRIP)
              begin
                // Both generators run on every byte bit so the caller picks the one it needs
                // A check mismatch never stops a transfer; the caller decides
                s_d.crc8 = {1'b0, s_q.crc8[7:1]} ^
                           ((s_q.crc8[0] ^ s_q.bitv) ? `SWM_CRC8_POLY : 8'h00);
                s_d.crc16 = {1'b0, s_q.crc16[15:1]} ^
                            ((s_q.crc16[0] ^ s_q.bitv) ? `SWM_CRC16_POLY : 16'h0000);
              end
            end
          end
        end
        ST_REC:
        begin
          s_d.cnt = s_q.cnt + CW'(1);
          if (s_q.cnt == RecEnd)
          begin
            if (s_q.bitIdx >= s_q.nBits)
            begin
              s_d.st = ST_IDLE;
              s_d.rspValid = 1'b1;
              s_d.rsp.data = s_q.shreg;
            end
            else
              s_d = startSlot(s_q);
          end
        end
        ST_PROG:
        begin
          s_d.cnt = s_q.cnt + CW'(1);
          s_d.drive = 1'b0;
          if (s_q.cnt == ProgEnd)
          begin
            s_d.prog = 1'b0;
            s_d.cnt = '0;
            s_d.st = ST_REC;
          end
        end
        default:
        begin
          s_d.st = ST_IDLE;
          s_d.drive = 1'b0;
          s_d.prog = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
    end
    else
      s_q <= s_d;
  end

  assign cmdReady   = ce && (s_q.st == ST_IDLE);
  assign rspValid   = s_q.rspValid;
  assign rsp        = s_q.rsp;
  assign crc8       = s_q.crc8;
  assign crc16      = s_q.crc16;
  assign lineOut    = 1'b0;
  assign lineOe     = s_q.drive;
  assign progEnable = s_q.prog;

  sequence slotBegin;
    $rose(s_q.st == ST_SLOT) && s_q.slotCnt == 4'h1;
  endsequence

  sequence driveEnds;
    $fell(lineOe);
  endsequence

  reset_low_a: assert property (@(posedge sys_clk) disable iff (rst)
    driveEnds and (s_q.op == OP_RESET) |-> $past(s_q.lowRun) >= RstLow - CW'(1))
    else $error("reset pulse shorter than minimum");
  slot_start_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(s_q.st == ST_SLOT) |-> lineOe)
    else $error("slot did not begin with line low");
  idle_release_a: assert property (@(posedge sys_clk) disable iff (rst)
    (s_q.st == ST_IDLE) && $past(s_q.st == ST_IDLE) |-> !lineOe)
    else $error("line held low while idle");
  low_limit_a: assert property (@(posedge sys_clk) disable iff (rst)
    (s_q.op != OP_RESET) && lineOe |-> s_q.lowRun < LineMax)
    else $error("slot low exceeds slave reset threshold");
  prog_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(progEnable) |-> $past(s_q.crc16) == `SWM_CRC16_GOOD && !lineOe)
    else $error("program pulse without a clean check");
  prog_refuse_a: assert property (@(posedge sys_clk) disable iff (rst)
    ce && cmdReady && cmdValid && cmd.op == OP_PROG && crc16 != `SWM_CRC16_GOOD
    |=> rspValid && rsp.error && !progEnable)
    else $error("bad-check program request not refused");
  byte_slots_a: assert property (@(posedge sys_clk) disable iff (rst)
    rspValid && (s_q.op == OP_WBYTE || s_q.op == OP_RBYTE) |-> s_q.slotCnt == 4'h8)
    else $error("byte transfer not eight slots");
  trip_slots_a: assert property (@(posedge sys_clk) disable iff (rst)
    rspValid && s_q.op == OP_TRIP |-> s_q.slotCnt == 4'h3 && !rsp.error)
    else $error("search triplet not three slots");
  first_slot_a: assert property (@(posedge sys_clk) disable iff (rst)
    slotBegin and (s_q.op == OP_RESET) |-> lineOe && s_q.lowEnd == RstLow)
    else $error("reset slot set up wrongly");
  no_abort_a: assert property (@(posedge sys_clk) disable iff (rst)
    rspValid && s_q.op != OP_PROG |-> !rsp.error)
    else $error("transfer aborted");

endmodule // swm_master

// ### dv/swm_slave_model.sv
// Behavioural slave on the single data line, with timing scaled to the bench
`timescale 1ns/1ps
module swm_slave_model #(
  parameter logic [63:0] ID     = 64'h0000_0000_0000_0000,
  parameter int          PDH_NS = 2000
) (
  input  wire logic line,
  input  wire logic attached,
  output logic      pullLow
);
  logic    low = 1'b0;
  realtime t0;
  event    rstEv;
  // A detached slave never touches the line, but keeps listening
  assign pullLow = attached & low;
  // Any low longer than the longest slot low time counts as a reset pulse
  always @(negedge line)
  begin
    t0 = $realtime;
    @(posedge line);
    if ($realtime - t0 > 12400)
      ->rstEv;
  end
  task automatic rxBit(output logic b);
    @(negedge line);
    #9000 b = line;
    wait (line === 1'b1);
  endtask
  task automatic txBit(input logic b);
    @(negedge line);
    low = ~b;
    #12100 low = 1'b0;
    wait (line === 1'b1);
  endtask
  task automatic rxByte(output logic [7:0] v);
    for (int i = 0; i < 8; i++)
      rxBit(v[i]);
  endtask
  task automatic session();
    logic [7:0] c;
    logic       b;
    #PDH_NS low = 1'b1;
    #6000 low = 1'b0;
    rxByte(c);
    case (c)
      8'h33:
        for (int i = 0; i < 64; i++)
          txBit(ID[i]);
      8'h55:
      begin
        for (int i = 0; i < 64; i++)
        begin
          rxBit(b);
          if (b !== ID[i])
            return;
        end
        rxByte(c);
      end
      8'hCC: rxByte(c);
      8'hF0:
        for (int i = 0; i < 64; i++)
        begin
          txBit(ID[i]);
          txBit(~ID[i]);
          rxBit(b);
          if (b !== ID[i])
            return;
        end
      default: ;
    endcase
  endtask
  // A new reset abandons whatever the previous session was doing
  always @rstEv
  begin
    disable fork;
    low = 1'b0;
    fork
      session();
    join_none
  end
endmodule // swm_slave_model

// ### dv/swm_master_test.sv
// Self-checking bench: bus master against two slave models on one line
`timescale 1ns/1ps
module swm_master_test;
  import swm_pkg::*;
  localparam int RLO = 2600;
  localparam int PRG = 500;
  // Scaled timings; reset low must outlast the model's reset threshold, write-0 low must not
  localparam int RHI = 2000;
  localparam int PSM = 1000;
  localparam int SLT = 2500;
  localparam int W0L = 2300;
  function automatic logic [15:0] crcOf(input logic [63:0] v, input int n, input logic [15:0] p);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 0; i < n; i++)
      c = (c >> 1) ^ ((c[0] ^ v[i]) ? p : 16'h0000);
    return c;
  endfunction
  function automatic logic [63:0] mkId(input logic [55:0] v);
    logic [15:0] c;
    c = crcOf({8'h00, v}, 56, 16'h008C);
    return {c[7:0], v};
  endfunction
  // Identity values are arbitrary; they differ in their two lowest bits
  localparam logic [63:0] ID0 = mkId(56'h12_3456_789A_BC5A);
  localparam logic [63:0] ID1 = mkId(56'h65_4321_0FED_CBA5);
  logic        sysClk, rst, cmdValid, cmdReady, rspValid, crcLoad;
  logic        lineOut, lineOe, progEnable, att0, att1, low0, low1, ce;
  logic [15:0] crcSeed, crc16;
  logic [7:0]  crc8;
  swm_cmd_s    cmd;
  swm_rsp_s    rsp;
  int          n_fail = 0, n_checks = 0, cyc = 0, oeRun = 0, oeMax = 0, prRun = 0, prMax = 0;
  wire         line = ~lineOe & ~low0 & ~low1;
  swm_master #(.RST_LOW_CYC(RLO), .RST_HIGH_CYC(RHI), .PRES_SMP_CYC(PSM), .SLOT_CYC(SLT),
    .W0_LOW_CYC(W0L), .PROG_CYC(PRG)) swm_master_inst (.sys_clk(sysClk), .rst(rst), .ce(ce),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmd(cmd), .rspValid(rspValid), .rsp(rsp),
    .crcLoad(crcLoad), .crcSeed(crcSeed), .crc8(crc8), .crc16(crc16), .lineIn(line),
    .lineOut(lineOut), .lineOe(lineOe), .progEnable(progEnable));
  swm_slave_model #(.ID(ID0), .PDH_NS(2000)) swm_slave_model_inst0 (.line(line), .attached(att0),
    .pullLow(low0));
  swm_slave_model #(.ID(ID1), .PDH_NS(3000)) swm_slave_model_inst1 (.line(line), .attached(att1),
    .pullLow(low1));
  initial
  begin
    sysClk = 1'b0;
    forever #2.5 sysClk = ~sysClk;
  end
  always @(posedge sysClk)
  begin
    cyc <= cyc + 1;
    oeRun <= lineOe ? oeRun + 1 : 0;
    prRun <= progEnable ? prRun + 1 : 0;
    if (oeRun > oeMax)
      oeMax <= oeRun;
    if (prRun > prMax)
      prMax <= prRun;
    if (cyc == 200000)
    begin
      n_fail++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("Checks made %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  // Request held until taken, then wait for the one-cycle completion pulse
  task automatic doCmd(input swm_op_e op, input logic [7:0] d, input logic dir);
    int n;
    cmd = '{op, d, dir};
    cmdValid = 1'b1;
    while (cmdReady !== 1'b1)
      @(posedge sysClk) #1;
    @(posedge sysClk) #1;
    cmdValid = 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && n < 40000)
    begin
      @(posedge sysClk) #1;
      n++;
    end
    check(16'(n < 40000), 16'h0001, "completion");
  endtask
  task automatic tNoDevice();
    doCmd(OP_RESET, 8'h00, 1'b0);
    check(16'(rsp.presence), 16'h0000, "presence");
    check(16'(oeMax >= RLO), 16'h0001, "reset low");
    check(16'(lineOut), 16'h0000, "drive level");
  endtask
  task automatic tReadId();
    att0 = 1'b1;
    doCmd(OP_RESET, 8'h00, 1'b0);
    check(16'(rsp.presence), 16'h0001, "presence");
    doCmd(OP_WBYTE, 8'h33, 1'b0);
    check(16'(rsp.data), 16'h0033, "echo");
    doCmd(OP_RBYTE, 8'hFF, 1'b0);
    check(16'(rsp.data), 16'(ID0[7:0]), "family");
    check(16'(crc8), crcOf({48'h0, ID0[7:0], 8'h33}, 16, 16'h008C), "crc8");
    check(crc16, crcOf({48'h0, ID0[7:0], 8'h33}, 16, 16'hA001), "crc16");
  endtask
  task automatic tProgram();
    doCmd(OP_PROG, 8'h00, 1'b0);
    check(16'(rsp.error), 16'h0001, "refused");
    check(16'(prMax), 16'h0000, "no pulse");
    ce = 1'b0;
    crcLoad = 1'b1;
    crcSeed = 16'hB001;
    @(posedge sysClk) #1;
    check(16'(cmdReady), 16'h0000, "ready frozen");
    check(crc16, crcOf({48'h0, ID0[7:0], 8'h33}, 16, 16'hA001), "crc16 frozen");
    ce = 1'b1;
    @(posedge sysClk) #1;
    crcLoad = 1'b0;
    check(crc16, 16'hB001, "seed");
    check(16'(crc8), 16'h0000, "crc8 clear");
    doCmd(OP_PROG, 8'h00, 1'b0);
    check(16'(rsp.error), 16'h0000, "accepted");
    check(16'(prMax >= PRG), 16'h0001, "pulse width");
  endtask
  task automatic tSearch();
    att1 = 1'b1;
    doCmd(OP_RESET, 8'h00, 1'b0);
    check(16'(rsp.presence), 16'h0001, "presence");
    doCmd(OP_WBYTE, 8'hF0, 1'b0);
    doCmd(OP_TRIP, 8'h00, 1'b1);
    check(16'({rsp.tripBit, rsp.tripCmp}), 16'h0000, "conflict");
    doCmd(OP_TRIP, 8'h00, 1'b0);
    check(16'({rsp.tripBit, rsp.tripCmp}), 16'({ID1[1], ~ID1[1]}), "drop out");
  endtask
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    cmdValid = 1'b0;
    cmd = '0;
    crcLoad = 1'b0;
    crcSeed = 16'h0000;
    att0 = 1'b0;
    att1 = 1'b0;
    repeat (20) @(posedge sysClk);
    #1 rst = 1'b0;
    @(posedge sysClk) #1;
    tNoDevice();
    tReadId();
    tProgram();
    tSearch();
    stop_test();
  end
endmodule // swm_master_test
